/* File: hw/ddrsp_params.svh */
// offsets, field positions and counts of the ddr scheduler policy block
`ifndef DDRSP_PARAMS_SVH
`define DDRSP_PARAMS_SVH
`define DDRSP_CFG_OFFSET 8'h54
`define DDRSP_CFG_RESET 32'h0000_0000
`define DDRSP_PHL_LSB 14
`define DDRSP_PHL_MSB 15
`define DDRSP_ICL_LSB 16
`define DDRSP_ICL_MSB 18
`define DDRSP_RDIMM_BIT 27
`define DDRSP_RWS_BIT 28
`define DDRSP_TB_BIT 29
`define DDRSP_TA_BIT 30
`define DDRSP_SBW_BIT 31
`define DDRSP_PHL_EIGHT 2'h2
`define DDRSP_ICL_EIGHT 3'h1
`define DDRSP_CNT_W 6
`define DDRSP_CS_W 3
`define DDRSP_CMD_BITS 20
`endif

/* File: hw/ddrsp_pkg.sv */
// types of the ddr scheduler policy block
`default_nettype none
package ddrsp_pkg;
	typedef struct packed {
		logic [14:0] addr;
		logic row_n;
		logic col_n;
		logic we_n;
		logic cke;
		logic [3:0] cs_n;
	} ddrsp_cmd_t;
	typedef enum logic [1:0] {
		DDRSP_OP_NOP,
		DDRSP_OP_READ,
		DDRSP_OP_WRITE,
		DDRSP_OP_PREALL
	} ddrsp_op_t;
endpackage
`default_nettype wire

/* File: hw/ddrsp_delay.sv */
// one-cycle optional retiming stage for a command bus copy
`include "ddrsp_params.svh"
`default_nettype none
module ddrsp_delay
	import ddrsp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control and data
	input wire logic enable,
	input wire ddrsp_cmd_t din,
	output ddrsp_cmd_t dout
);
	ddrsp_cmd_t held;
	ddrsp_cmd_t next_held;
	ddrsp_cmd_t out_q;
	ddrsp_cmd_t next_out_q;
	// hold delay realised as late launch: straight or one stage later
	always_comb begin
		next_held = din;
		next_out_q = enable ? held : din;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			held <= '{addr: 15'h0, row_n: 1'b1, col_n: 1'b1, we_n: 1'b1,
				cke: 1'b0, cs_n: 4'hf};
			out_q <= '{addr: 15'h0, row_n: 1'b1, col_n: 1'b1, we_n: 1'b1,
				cke: 1'b0, cs_n: 4'hf};
		end else begin
			held <= next_held;
			out_q <= next_out_q;
		end
	end
	// pad outputs leave a flop whichever launch is chosen
	always_comb begin
		dout = out_q;
	end
endmodule
`default_nettype wire

/* File: hw/ddrsp_ctrl.sv */
// scheduler policy, idle close and read return timing of the ddr controller
`include "ddrsp_params.svh"
`default_nettype none
module ddrsp_ctrl
	import ddrsp_pkg::*;
#(
	parameter int DATA_W = 64
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// configuration register port
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	// arbiter candidates
	input wire logic hit_req_valid,
	input wire logic miss_req_valid,
	input wire logic req_is_write,
	input wire logic [`DDRSP_CS_W-1:0] req_cs,
	input wire logic [14:0] req_addr,
	output logic grant_hit,
	output logic grant_miss,
	// super bypass
	input wire logic bypass_req,
	input wire logic queues_empty,
	output logic bypass_ack,
	// read return
	input wire logic [DATA_W-1:0] strobe_data,
	input wire logic strobe_valid,
	output logic [DATA_W-1:0] rd_data,
	output logic rd_valid,
	// command bus copies
	output logic [14:0] bus_a_mem_address,
	output logic bus_a_row_strobe_n,
	output logic bus_a_col_strobe_n,
	output logic bus_a_write_enable_n,
	output logic bus_a_clock_enable,
	output logic [3:0] bus_a_cs_n,
	output logic [14:0] bus_b_mem_address,
	output logic bus_b_row_strobe_n,
	output logic bus_b_col_strobe_n,
	output logic bus_b_write_enable_n,
	output logic bus_b_clock_enable,
	output logic [3:0] bus_b_cs_n,
	output logic registered_dimm,
	output logic precharge_all
);
	logic [31:0] cfg, next_cfg;
	logic [`DDRSP_CNT_W-1:0] hit_cnt, next_hit_cnt;
	logic [`DDRSP_CNT_W-1:0] idle_cnt, next_idle_cnt;
	logic idle_done, next_idle_done;
	logic [`DDRSP_CS_W-1:0] act_cs, next_act_cs;
	logic g_hit, g_miss, next_g_hit, next_g_miss;
	logic last_read, next_last_read;
	logic byp_pend, next_byp_pend, byp_ack, next_byp_ack;
	logic pre, next_pre;
	logic [DATA_W-1:0] cap0, cap1, ret1, ret2;
	logic v0, v1, vr1, vr2;
	logic [DATA_W-1:0] next_rd_data;
	logic next_rd_valid;
	logic [`DDRSP_CNT_W-1:0] hit_limit, idle_limit;
	logic wr_hold;
	ddrsp_cmd_t next_cmd, cmd_a, cmd_b;

	// limit decode: code n -> 2^(n+1) hits, code n -> 4*2^n idle clocks for n up to 3, codes 3 to 7 all 32
	always_comb begin
		case (cfg[`DDRSP_PHL_MSB:`DDRSP_PHL_LSB])
			2'h0: hit_limit = 6'h02;
			2'h1: hit_limit = 6'h04;
			`DDRSP_PHL_EIGHT: hit_limit = 6'h08;
			default: hit_limit = 6'h10;
		endcase
		case (cfg[`DDRSP_ICL_MSB:`DDRSP_ICL_LSB])
			3'h0: idle_limit = 6'h04;
			`DDRSP_ICL_EIGHT: idle_limit = 6'h08;
			3'h2: idle_limit = 6'h10;
			default: idle_limit = 6'h20;
		endcase
	end

	// configuration register
	always_comb begin
		next_cfg = cfg;
		if (cfg_wr && cfg_addr == `DDRSP_CFG_OFFSET) begin
			next_cfg = cfg_wdata;
		end
	end

	// arbiter and write turnaround
	always_comb begin
		wr_hold = last_read && cfg[`DDRSP_RWS_BIT] && req_is_write;
		next_g_hit = 1'b0;
		next_g_miss = 1'b0;
		next_hit_cnt = hit_cnt;
		next_act_cs = act_cs;
		next_last_read = 1'b0;
		next_cmd = '{addr: 15'h0, row_n: 1'b1, col_n: 1'b1, we_n: 1'b1,
			cke: 1'b1, cs_n: 4'hf};
		if (!wr_hold) begin
			if (miss_req_valid && (!hit_req_valid || hit_cnt >= hit_limit)) begin
				next_g_miss = 1'b1;
				next_hit_cnt = '0;
				next_act_cs = req_cs;
			end else if (hit_req_valid) begin
				next_g_hit = 1'b1;
				if (req_cs != act_cs) begin
					next_hit_cnt = 6'h01;
				end else if (hit_cnt < hit_limit) begin
					next_hit_cnt = hit_cnt + 6'h01;
				end
				next_act_cs = req_cs;
			end
		end
		if (next_g_hit || next_g_miss) begin
			next_last_read = !req_is_write;
			next_cmd.addr = req_addr;
			next_cmd.col_n = 1'b0;
			next_cmd.we_n = !req_is_write;
			next_cmd.cs_n = ~(4'h1 << req_cs[1:0]);
		end
		if (pre) begin
			next_cmd.row_n = 1'b0;
			next_cmd.we_n = 1'b0;
			next_cmd.addr = 15'h0400;
		end
	end

	// idle close: counts request-free clocks only
	always_comb begin
		next_idle_cnt = idle_cnt;
		next_idle_done = idle_done;
		next_pre = 1'b0;
		if (hit_req_valid || miss_req_valid || bypass_req) begin
			next_idle_cnt = '0;
			next_idle_done = 1'b0;
		end else if (!idle_done) begin
			next_idle_cnt = idle_cnt + 6'h01;
			if (idle_cnt + 6'h01 == idle_limit) begin
				next_pre = 1'b1;
				next_idle_done = 1'b1;
			end
		end
	end

	// super bypass with optional wait state
	always_comb begin
		next_byp_pend = 1'b0;
		next_byp_ack = 1'b0;
		if (bypass_req && queues_empty && !byp_ack) begin
			if (cfg[`DDRSP_SBW_BIT] && !byp_pend) begin
				next_byp_pend = 1'b1;
			end else begin
				next_byp_ack = 1'b1;
			end
		end
	end

	// read return: two-flop capture, optional pad register stage
	always_comb begin
		next_rd_valid = cfg[`DDRSP_RWS_BIT] ? vr2 : vr1;
		next_rd_data = cfg[`DDRSP_RWS_BIT] ? ret2 : ret1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cfg <= `DDRSP_CFG_RESET;
			hit_cnt <= '0;
			idle_cnt <= '0;
			idle_done <= 1'b0;
			act_cs <= '0;
			g_hit <= 1'b0;
			g_miss <= 1'b0;
			last_read <= 1'b0;
			byp_pend <= 1'b0;
			byp_ack <= 1'b0;
			pre <= 1'b0;
			{cap0, cap1, ret1, ret2, rd_data} <= '0;
			{v0, v1, vr1, vr2, rd_valid} <= '0;
		end else begin
			cfg <= next_cfg;
			hit_cnt <= next_hit_cnt;
			idle_cnt <= next_idle_cnt;
			idle_done <= next_idle_done;
			act_cs <= next_act_cs;
			g_hit <= next_g_hit;
			g_miss <= next_g_miss;
			last_read <= next_last_read;
			byp_pend <= next_byp_pend;
			byp_ack <= next_byp_ack;
			pre <= next_pre;
			// strobe-domain data passes two flops before use
			cap0 <= strobe_data;
			v0 <= strobe_valid;
			cap1 <= cap0;
			v1 <= v0;
			ret1 <= cap1;
			vr1 <= v1;
			ret2 <= ret1;
			vr2 <= vr1;
			rd_data <= next_rd_data;
			rd_valid <= next_rd_valid;
		end
	end

	// per-copy late launch; outputs still leave a flop
	ddrsp_delay u_dly_a (
		.clk(clk),
		.reset(reset),
		.enable(cfg[`DDRSP_TA_BIT]),
		.din(next_cmd),
		.dout(cmd_a)
	);
	ddrsp_delay u_dly_b (
		.clk(clk),
		.reset(reset),
		.enable(cfg[`DDRSP_TB_BIT]),
		.din(next_cmd),
		.dout(cmd_b)
	);

	always_comb begin
		cfg_rdata = cfg;
		grant_hit = g_hit;
		grant_miss = g_miss;
		bypass_ack = byp_ack;
		precharge_all = pre;
		registered_dimm = cfg[`DDRSP_RDIMM_BIT];
		bus_a_mem_address = cmd_a.addr;
		bus_a_row_strobe_n = cmd_a.row_n;
		bus_a_col_strobe_n = cmd_a.col_n;
		bus_a_write_enable_n = cmd_a.we_n;
		bus_a_clock_enable = cmd_a.cke;
		bus_a_cs_n = cmd_a.cs_n;
		bus_b_mem_address = cmd_b.addr;
		bus_b_row_strobe_n = cmd_b.row_n;
		bus_b_col_strobe_n = cmd_b.col_n;
		bus_b_write_enable_n = cmd_b.we_n;
		bus_b_clock_enable = cmd_b.cke;
		bus_b_cs_n = cmd_b.cs_n;
	end

	a_hit_limit: assert property (@(posedge clk) disable iff (reset)
		grant_hit |-> hit_cnt <= hit_limit)
		else $error("page hit streak exceeded limit");
	a_miss_clear: assert property (@(posedge clk) disable iff (reset)
		grant_miss |-> hit_cnt == 6'h00)
		else $error("hit count not cleared on miss grant");
	a_idle_pre: assert property (@(posedge clk) disable iff (reset)
		precharge_all |-> $past(idle_cnt) + 6'h01 == $past(idle_limit))
		else $error("precharge-all at wrong idle count");
	a_idle_clear: assert property (@(posedge clk) disable iff (reset)
		(hit_req_valid || miss_req_valid) |=> idle_cnt == 6'h00)
		else $error("idle count not cleared by activity");
	a_byp_empty: assert property (@(posedge clk) disable iff (reset)
		bypass_ack |-> $past(queues_empty))
		else $error("bypass acked with busy queues");
	a_byp_wait: assert property (@(posedge clk) disable iff (reset)
		(cfg[`DDRSP_SBW_BIT] && bypass_ack) |-> $past(byp_pend))
		else $error("bypass wait state skipped");
	a_rd_turn: assert property (@(posedge clk) disable iff (reset)
		(cfg[`DDRSP_RWS_BIT] && last_read && req_is_write)
		|=> !grant_hit && !grant_miss)
		else $error("write issued straight after read");
	a_rd_wait: assert property (@(posedge clk) disable iff (reset)
		(cfg[`DDRSP_RWS_BIT] && $stable(cfg) && v1) |-> ##3 rd_valid)
		else $error("read wait delivery timing wrong");
	c_hit_cap: cover property (@(posedge clk) hit_cnt == hit_limit
		&& grant_miss);
	c_pre: cover property (@(posedge clk) precharge_all);
	c_byp: cover property (@(posedge clk) bypass_ack
		&& cfg[`DDRSP_SBW_BIT]);
endmodule
`default_nettype wire

/* File: tb/ddrsp_dimm_model.sv */
// dimm model: answers read commands on bus copy a with strobe data
`default_nettype none
module ddrsp_dimm_model (
	// clock
	input wire logic clk,
	// command bus copy a
	input wire logic bus_a_col_strobe_n,
	input wire logic bus_a_write_enable_n,
	// read return
	output logic [63:0] strobe_data,
	output logic strobe_valid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] pend = 3'h0;
	logic [63:0] beat = 64'h0123_4567_89ab_cdef;
	logic valid_q = 1'b0;
	logic [63:0] data_q = 64'h0;
	assign strobe_valid = valid_q;
	assign strobe_data = data_q;
	always @(posedge clk) begin
		pend <= {pend[1:0], !bus_a_col_strobe_n && bus_a_write_enable_n};
	end
	// idle data lines flip so a stale beat can never pass as fresh
	always @(negedge clk) begin
		valid_q <= pend[2];
		data_q <= pend[2] ? beat : ~data_q;
		if (pend[2])
			beat <= beat + 64'h1;
	end
endmodule
`default_nettype wire

/* File: tb/ddrsp_ctrl_test.sv */
// self-checking bench of the ddr scheduler policy block
`default_nettype none
module ddrsp_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic cfg_wr = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [31:0] cfg_wdata = 32'h0;
	logic hit_req_valid = 1'b0;
	logic miss_req_valid = 1'b0;
	logic req_is_write = 1'b0;
	logic [2:0] req_cs = 3'h0;
	logic [14:0] req_addr = 15'h0a5;
	logic bypass_req = 1'b0;
	logic queues_empty = 1'b1;
	logic [63:0] strobe_data, rd_data, beat_exp;
	logic [31:0] cfg_rdata;
	logic [14:0] bus_a_mem_address;
	logic [3:0] bus_a_cs_n;
	logic strobe_valid, grant_hit, grant_miss, bypass_ack, rd_valid;
	logic bus_a_row_strobe_n, bus_a_col_strobe_n, bus_a_write_enable_n;
	logic bus_b_col_strobe_n, registered_dimm, precharge_all;
	int fails = 0;
	int checks = 0;
	int n, c8, c4;
	always #50 clk = ~clk;
	ddrsp_ctrl dut (.clk(clk), .reset(reset), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.hit_req_valid(hit_req_valid), .miss_req_valid(miss_req_valid),
		.req_is_write(req_is_write), .req_cs(req_cs), .req_addr(req_addr),
		.grant_hit(grant_hit), .grant_miss(grant_miss),
		.bypass_req(bypass_req), .queues_empty(queues_empty),
		.bypass_ack(bypass_ack), .strobe_data(strobe_data),
		.strobe_valid(strobe_valid), .rd_data(rd_data), .rd_valid(rd_valid),
		.bus_a_mem_address(bus_a_mem_address),
		.bus_a_row_strobe_n(bus_a_row_strobe_n),
		.bus_a_col_strobe_n(bus_a_col_strobe_n),
		.bus_a_write_enable_n(bus_a_write_enable_n),
		.bus_a_clock_enable(), .bus_a_cs_n(bus_a_cs_n),
		.bus_b_mem_address(), .bus_b_row_strobe_n(),
		.bus_b_col_strobe_n(bus_b_col_strobe_n), .bus_b_write_enable_n(),
		.bus_b_clock_enable(), .bus_b_cs_n(),
		.registered_dimm(registered_dimm), .precharge_all(precharge_all));
	ddrsp_dimm_model dimm (.clk(clk), .bus_a_col_strobe_n(bus_a_col_strobe_n),
		.bus_a_write_enable_n(bus_a_write_enable_n),
		.strobe_data(strobe_data), .strobe_valid(strobe_valid));
	task automatic stop_test();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_sig(input int w, input int lim, input bit must,
		output int cnt);
		cnt = 0;
		do begin
			@(posedge clk);
			#1;
			cnt++;
		end while ((w == 2 ? precharge_all : bypass_ack) !== 1'b1 && cnt < lim);
		if (must && cnt >= lim) begin
			chk(cnt, 0);
			stop_test();
		end
	endtask
	task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge clk);
		cfg_wr = 1'b0;
	endtask
	// valid stands for the taking edge only, so one grant per request
	task automatic offer(input logic h, input logic m, input logic w);
		@(negedge clk);
		hit_req_valid = h;
		miss_req_valid = m;
		req_is_write = w;
		@(negedge clk);
		hit_req_valid = 1'b0;
		miss_req_valid = 1'b0;
	endtask
	task automatic read_test(input logic [31:0] cfg, input int ea,
		input int eb, input int erd);
		int ta;
		int tb;
		int ts;
		int tr;
		logic [63:0] got;
		ta = 0;
		tb = 0;
		ts = 0;
		tr = 0;
		cfg_write(8'h54, cfg);
		chk(cfg_rdata, cfg);
		chk(registered_dimm, cfg[27]);
		@(negedge clk);
		miss_req_valid = 1'b1;
		req_is_write = 1'b0;
		// i counts edges from the one that takes the read
		for (int i = 1; i < 20; i++) begin
			@(posedge clk);
			#1;
			if (!bus_a_col_strobe_n && ta == 0) begin
				ta = i;
				chk({bus_a_mem_address, bus_a_cs_n}, {15'h0a5, 4'he});
			end
			if (!bus_b_col_strobe_n && tb == 0)
				tb = i;
			if (strobe_valid && ts == 0)
				ts = i;
			if (rd_valid && tr == 0) begin
				tr = i;
				got = rd_data;
			end
			if (i == 1) begin
				@(negedge clk);
				miss_req_valid = 1'b0;
			end
		end
		chk(ta, ea);
		chk(tb, eb);
		chk(tr - ts, erd);
		chk(got, beat_exp);
		beat_exp = beat_exp + 64'h1;
	endtask
	task automatic rw_gap(input logic [31:0] cfg, output int g);
		cfg_write(8'h54, cfg);
		@(negedge clk);
		miss_req_valid = 1'b1;
		req_is_write = 1'b0;
		// write follows straight on the edge after the read grant
		@(negedge clk);
		req_is_write = 1'b1;
		g = 0;
		do begin
			@(posedge clk);
			#1;
			g++;
		end while (grant_miss !== 1'b1 && g < 20);
		if (g >= 20) begin
			chk(g, 0);
			stop_test();
		end
		@(negedge clk);
		miss_req_valid = 1'b0;
	endtask
	task automatic hit_run(input logic [1:0] code, input int lim);
		cfg_write(8'h54, 32'h0001_0000 | {16'h0, code, 14'h0});
		offer(1'b0, 1'b1, 1'b1);
		for (int i = 0; i <= lim + 1; i++) begin
			offer(1'b1, 1'b1, 1'b1);
			chk({grant_hit, grant_miss}, (i == lim) ? 2'b01 : 2'b10);
		end
	endtask
	task automatic idle_run(input logic [31:0] cfg, output int c);
		cfg_write(8'h54, cfg);
		offer(1'b0, 1'b1, 1'b1);
		wait_sig(2, 40, 1'b1, c);
	endtask
	task automatic bypass(input logic [31:0] cfg, input logic e, input int x);
		cfg_write(8'h54, cfg);
		@(negedge clk);
		queues_empty = e;
		bypass_req = 1'b1;
		wait_sig(3, 12, e, n);
		chk(n, x);
		@(negedge clk);
		bypass_req = 1'b0;
		queues_empty = 1'b1;
	endtask
	initial begin
		beat_exp = 64'h0123_4567_89ab_cdef;
		repeat (10) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		@(posedge clk);
		#1;
		chk({cfg_rdata, bus_a_cs_n, bus_a_row_strobe_n}, {32'h0, 4'hf, 1'b1});
		cfg_write(8'h50, 32'hffff_ffff);
		chk(cfg_rdata, 32'h0);
		$display("test reset done");
		read_test(32'h0001_8000, 1, 1, 3);
		read_test(32'h5801_8000, 2, 1, 4);
		read_test(32'h3801_8000, 1, 2, 4);
		$display("test read done");
		rw_gap(32'h0001_8000, n);
		chk(n, 1);
		rw_gap(32'h1001_8000, n);
		chk(n, 2);
		$display("test turnaround done");
		hit_run(2'h2, 8);
		hit_run(2'h0, 2);
		$display("test page hit done");
		idle_run(32'h0001_8000, c8);
		idle_run(32'h0000_8000, c4);
		chk(c8 - c4, 4);
		chk(c4 > 2 && c4 < 7, 1);
		wait_sig(2, 30, 1'b0, n);
		chk(n, 30);
		$display("test idle done");
		bypass(32'h0001_8000, 1'b1, 1);
		bypass(32'h8001_8000, 1'b1, 2);
		bypass(32'h0001_8000, 1'b0, 12);
		$display("test bypass done");
		stop_test();
	end
endmodule
`default_nettype wire
